// *** hdl/ccb_cti_detect.v ***
`timescale 1ns/10ps
`default_nettype none
`include "ccb_map.vh"
module ccb_cti_detect (
    input  wire [31:0] instr,
    output wire        is_cti
);
    wire [5:0] op;
    wire [4:0] rs;
    wire [4:0] rt;
    wire [4:0] rd;
    wire [4:0] sa;
    wire [5:0] fn;
    reg        cti;

    assign op = instr[`CCB_OP_HI:`CCB_OP_LO];
    assign rs = instr[`CCB_RS_HI:`CCB_RS_LO];
    assign rt = instr[`CCB_RT_HI:`CCB_RT_LO];
    assign rd = instr[`CCB_RD_HI:`CCB_RD_LO];
    assign sa = instr[`CCB_SA_HI:`CCB_SA_LO];
    assign fn = instr[`CCB_FN_HI:`CCB_FN_LO];

    // branches, jumps, link-without-branch, returns, wait, pause
    always @* begin
        cti = 1'b0;
        case (op)
            `CCB_OP_SPECIAL: begin
                cti = (fn == `CCB_FN_JR) || (fn == `CCB_FN_JALR) ||
                      ((fn == `CCB_FN_SLL) && (rt == `CCB_REG_ZERO) &&
                       (rd == `CCB_REG_ZERO) && (sa == `CCB_SA_PAUSE));
            end
            `CCB_OP_REGIMM: begin
                // regimm branches and the link-without-branch form
                cti = (rt[3:2] == 2'b00);
            end
            `CCB_OP_COP0: begin
                cti = instr[`CCB_CO_BIT] &&
                      ((fn == `CCB_FN_ERET) || (fn == `CCB_FN_DERET) ||
                       (fn == `CCB_FN_WAIT));
            end
            `CCB_OP_COP1: begin
                cti = (rs == `CCB_CP_BC_EQZ) || (rs == `CCB_CP_BC_NEZ);
            end
            `CCB_OP_COP2: begin
                cti = (rs == `CCB_CP2_BC_EQZ) || (rs == `CCB_CP_BC_NEZ);
            end
            `CCB_OP_J, `CCB_OP_JAL, `CCB_OP_BEQ, `CCB_OP_BNE,
            `CCB_OP_UGE, `CCB_OP_ULT, `CCB_OP_EQ, `CCB_OP_NE,
            `CCB_OP_BEQL, `CCB_OP_BNEL, `CCB_OP_LE_GE, `CCB_OP_GT_LT,
            `CCB_OP_BC, `CCB_OP_BALC, `CCB_OP_ZERO_LONG,
            `CCB_OP_NZ_LONG: begin
                cti = 1'b1;
            end
            default: begin
                cti = 1'b0;
            end
        endcase
    end

    assign is_cti = cti;
endmodule // ccb_cti_detect
`default_nettype wire

// *** hdl/ccb_unit.v ***
// Overview of operation
// - opcode groups le_ge, gt_lt split by fields
// - 000111/000110 distinct nonzero: unsigned less, ge
// - 001000 with rs below rt: registers equal
// - 011000 with rs below rt: registers unequal
// - 110110 nonzero rs: is zero, 21-bit offset
// - 111110 nonzero rs: not zero, 21-bit offset
// - 16-bit offset except both long zero forms
// - target: sign-extended offset*4 plus next address
// - equal/unequal compare full 32 bits
// - signed compares use two's complement order
// - unsigned compares use plain magnitude order
// - short zero compares test rt signed
// - long zero compares test rs against zero
// - no delay slot; taken skips next instruction
// - control transfer in untaken forbidden slot: exception
// - which instructions count as control transfers
// - likely form: branch after slot, else nullify
// - likely form: 16-bit offset plus slot address
`timescale 1ns/10ps
`default_nettype none
`include "ccb_map.vh"
module ccb_unit (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        issue_valid,
    input  wire [31:0] issue_instr,
    input  wire [31:0] issue_pc,
    input  wire [31:0] first_source_val,
    input  wire [31:0] second_source_val,
    output reg         resolve_q,
    output reg         is_compact_q,
    output reg         taken_q,
    output reg  [3:0]  kind_q,
    output reg  [31:0] target_q,
    output reg  [31:0] fetch_pc_q,
    output reg         skip_next_q,
    output reg         nullify_slot_q,
    output reg         redirect_q,
    output reg  [31:0] redirect_pc_q,
    output reg         reserved_instr_exc_q,
    output reg  [31:0] exc_pc_q,
    output reg  [`CCB_K_LAST:1] kind_hit_q
);
    wire [5:0]  op;
    wire [4:0]  first_source_field;
    wire [4:0]  second_source_field;
    wire        rs_nz;
    wire        rt_nz;
    wire        rs_eq_rt;
    wire        rs_lt_rt;
    wire        is_cti;
    wire        slot_exc;
    wire        issue_ok;
    wire [31:0] seq_pc;
    wire [31:0] off_short;
    wire [31:0] off_long;
    wire [31:0] target_d;
    wire        regs_same;
    wire        signed_less;
    wire        unsigned_less;
    wire        rt_is_zero;
    wire        rt_is_neg;
    wire        rs_is_zero;
    wire        rs_is_neg;
    reg  [3:0]  kind_d;
    reg         long_off_d;
    reg         cond_d;
    reg         forbid_armed_q;
    reg         likely_pend_q;
    reg         likely_taken_q;
    reg  [31:0] likely_target_q;

    assign op = issue_instr[`CCB_OP_HI:`CCB_OP_LO];
    assign first_source_field  = issue_instr[`CCB_RS_HI:`CCB_RS_LO];
    assign second_source_field = issue_instr[`CCB_RT_HI:`CCB_RT_LO];
    assign rs_nz    = (first_source_field != `CCB_REG_ZERO);
    assign rt_nz    = (second_source_field != `CCB_REG_ZERO);
    assign rs_eq_rt = (first_source_field == second_source_field);
    assign rs_lt_rt = (first_source_field < second_source_field);

    ccb_cti_detect u_cti (
        .instr  (issue_instr),
        .is_cti (is_cti)
    );

    // control transfer in the forbidden slot of an untaken compact branch
    assign slot_exc = issue_valid && forbid_armed_q && is_cti;
    assign issue_ok = issue_valid && !slot_exc;

    // field decode of the compact and legacy branch encodings
    always @* begin
        kind_d     = `CCB_K_NONE;
        long_off_d = 1'b0;
        case (op)
            `CCB_OP_LE_GE: begin
                if (!rs_nz && rt_nz) begin
                    kind_d = `CCB_K_AT_BELOW_Z;
                end else if (rs_nz && rt_nz && rs_eq_rt) begin
                    kind_d = `CCB_K_AT_ABOVE_Z;
                end else if (rs_nz && rt_nz) begin
                    kind_d = `CCB_K_S_GE;
                end
            end
            `CCB_OP_GT_LT: begin
                if (!rs_nz && rt_nz) begin
                    kind_d = `CCB_K_ABOVE_Z;
                end else if (rs_nz && rt_nz && rs_eq_rt) begin
                    kind_d = `CCB_K_BELOW_Z;
                end else if (rs_nz && rt_nz) begin
                    kind_d = `CCB_K_S_LT;
                end
            end
            `CCB_OP_ULT: begin
                if (rs_nz && rt_nz && !rs_eq_rt) begin
                    kind_d = `CCB_K_U_LT;
                end
            end
            `CCB_OP_UGE: begin
                if (rs_nz && rt_nz && !rs_eq_rt) begin
                    kind_d = `CCB_K_U_GE;
                end
            end
            `CCB_OP_EQ: begin
                if (rs_nz && rt_nz && rs_lt_rt) begin
                    kind_d = `CCB_K_REGS_EQ;
                end
            end
            `CCB_OP_NE: begin
                if (rs_nz && rt_nz && rs_lt_rt) begin
                    kind_d = `CCB_K_REGS_NE;
                end
            end
            `CCB_OP_ZERO_LONG: begin
                if (rs_nz) begin
                    kind_d     = `CCB_K_IS_Z_LONG;
                    long_off_d = 1'b1;
                end
            end
            `CCB_OP_NZ_LONG: begin
                if (rs_nz) begin
                    kind_d     = `CCB_K_NZ_LONG;
                    long_off_d = 1'b1;
                end
            end
            `CCB_OP_REGIMM: begin
                if (second_source_field == `CCB_RT_LIKELY_GE) begin
                    kind_d = `CCB_K_LIKELY_GE;
                end
            end
            default: begin
                kind_d     = `CCB_K_NONE;
                long_off_d = 1'b0;
            end
        endcase
    end

    // operand comparisons on the full register values
    assign regs_same     = (first_source_val == second_source_val);
    assign signed_less   = ($signed(first_source_val) <
                            $signed(second_source_val));
    assign unsigned_less = (first_source_val < second_source_val);
    assign rt_is_zero    = (second_source_val == 32'h0000_0000);
    assign rt_is_neg     = second_source_val[`CCB_SIGN_BIT];
    assign rs_is_zero    = (first_source_val == 32'h0000_0000);
    assign rs_is_neg     = first_source_val[`CCB_SIGN_BIT];

    // branch condition per kind
    always @* begin
        cond_d = 1'b0;
        case (kind_d)
            `CCB_K_REGS_EQ: begin
                cond_d = regs_same;
            end
            `CCB_K_REGS_NE: begin
                cond_d = !regs_same;
            end
            `CCB_K_S_LT: begin
                cond_d = signed_less;
            end
            `CCB_K_S_GE: begin
                cond_d = !signed_less;
            end
            `CCB_K_U_LT: begin
                cond_d = unsigned_less;
            end
            `CCB_K_U_GE: begin
                cond_d = !unsigned_less;
            end
            `CCB_K_BELOW_Z: begin
                cond_d = rt_is_neg;
            end
            `CCB_K_AT_BELOW_Z: begin
                cond_d = rt_is_neg || rt_is_zero;
            end
            `CCB_K_AT_ABOVE_Z: begin
                cond_d = !rt_is_neg;
            end
            `CCB_K_ABOVE_Z: begin
                cond_d = !rt_is_neg && !rt_is_zero;
            end
            `CCB_K_IS_Z_LONG: begin
                cond_d = rs_is_zero;
            end
            `CCB_K_NZ_LONG: begin
                cond_d = !rs_is_zero;
            end
            `CCB_K_LIKELY_GE: begin
                cond_d = !rs_is_neg;
            end
            default: begin
                cond_d = 1'b0;
            end
        endcase
    end

    // pc-relative target from the following instruction's address
    assign seq_pc    = issue_pc + `CCB_INSN_BYTES;
    assign off_short = {{14{issue_instr[`CCB_OFF16_HI]}},
                        issue_instr[`CCB_OFF16_HI:0], 2'b00};
    assign off_long  = {{9{issue_instr[`CCB_OFF21_HI]}},
                        issue_instr[`CCB_OFF21_HI:0], 2'b00};
    assign target_d  = seq_pc + (long_off_d ? off_long : off_short);

    // resolve outputs, one cycle after the branch is issued
    always @(posedge clk_sys) begin
        if (rst) begin
            resolve_q      <= 1'b0;
            is_compact_q   <= 1'b0;
            taken_q        <= 1'b0;
            kind_q         <= `CCB_K_NONE;
            target_q       <= 32'h0000_0000;
            fetch_pc_q     <= 32'h0000_0000;
            skip_next_q    <= 1'b0;
            nullify_slot_q <= 1'b0;
        end else if (clk_en) begin
            resolve_q    <= issue_ok && (kind_d != `CCB_K_NONE);
            is_compact_q <= issue_ok && (kind_d != `CCB_K_NONE) &&
                            (kind_d != `CCB_K_LIKELY_GE);
            taken_q      <= issue_ok && cond_d;
            kind_q       <= issue_ok ? kind_d : `CCB_K_NONE;
            target_q     <= target_d;
            // taken selects the target, otherwise the next address
            fetch_pc_q   <= (issue_ok && cond_d) ? target_d : seq_pc;
            // a taken compact branch squashes the sequential instruction
            skip_next_q  <= issue_ok && cond_d &&
                            (kind_d != `CCB_K_LIKELY_GE);
            nullify_slot_q <= issue_ok && !cond_d &&
                              (kind_d == `CCB_K_LIKELY_GE);
        end
    end

    // forbidden slot tracking after an untaken compact branch
    always @(posedge clk_sys) begin
        if (rst) begin
            forbid_armed_q       <= 1'b0;
            reserved_instr_exc_q <= 1'b0;
            exc_pc_q             <= 32'h0000_0000;
        end else if (clk_en) begin
            reserved_instr_exc_q <= slot_exc;
            if (slot_exc) begin
                exc_pc_q <= issue_pc;
            end
            if (issue_valid) begin
                // arm only when not taken; a taken branch has no slot
                forbid_armed_q <= issue_ok && !cond_d &&
                                  (kind_d != `CCB_K_NONE) &&
                                  (kind_d != `CCB_K_LIKELY_GE);
            end
        end
    end

    // likely form: redirect once the delay-slot instruction issues
    always @(posedge clk_sys) begin
        if (rst) begin
            likely_pend_q   <= 1'b0;
            likely_taken_q  <= 1'b0;
            likely_target_q <= 32'h0000_0000;
            redirect_q      <= 1'b0;
            redirect_pc_q   <= 32'h0000_0000;
        end else if (clk_en) begin
            redirect_q <= 1'b0;
            if (likely_pend_q && issue_valid) begin
                // delay slot seen: branch after it, or it was nullified
                likely_pend_q <= 1'b0;
                redirect_q    <= likely_taken_q;
                redirect_pc_q <= likely_target_q;
            end else if (issue_ok && (kind_d == `CCB_K_LIKELY_GE)) begin
                likely_pend_q   <= 1'b1;
                likely_taken_q  <= cond_d;
                likely_target_q <= target_d;
            end else if (issue_ok && cond_d) begin
                // compact branch: redirect at once, no delay slot
                redirect_q    <= 1'b1;
                redirect_pc_q <= target_d;
            end
        end
    end

    // one flag per decoded branch kind
    genvar g;
    generate
        for (g = 1; g <= `CCB_K_LAST; g = g + 1) begin : g_hit
            localparam [3:0] KC = g;
            always @(posedge clk_sys) begin
                if (rst) begin
                    kind_hit_q[g] <= 1'b0;
                end else if (clk_en) begin
                    kind_hit_q[g] <= issue_ok && (kind_d == KC);
                end
            end
        end
    endgenerate
endmodule // ccb_unit
`default_nettype wire

// *** shared/ccb_map.vh ***
`ifndef CCB_MAP_VH
`define CCB_MAP_VH
// instruction field positions
`define CCB_OP_HI        31
`define CCB_OP_LO        26
`define CCB_RS_HI        25
`define CCB_RS_LO        21
`define CCB_RT_HI        20
`define CCB_RT_LO        16
`define CCB_RD_HI        15
`define CCB_RD_LO        11
`define CCB_SA_HI        10
`define CCB_SA_LO        6
`define CCB_FN_HI        5
`define CCB_FN_LO        0
`define CCB_OFF16_HI     15
`define CCB_OFF21_HI     20
`define CCB_SIGN_BIT     31
`define CCB_CO_BIT       25
// primary opcodes
`define CCB_OP_SPECIAL   6'h00
`define CCB_OP_REGIMM    6'h01
`define CCB_OP_J         6'h02
`define CCB_OP_JAL       6'h03
`define CCB_OP_BEQ       6'h04
`define CCB_OP_BNE       6'h05
`define CCB_OP_UGE       6'h06
`define CCB_OP_ULT       6'h07
`define CCB_OP_EQ        6'h08
`define CCB_OP_COP0      6'h10
`define CCB_OP_COP1      6'h11
`define CCB_OP_COP2      6'h12
`define CCB_OP_BEQL      6'h14
`define CCB_OP_BNEL      6'h15
`define CCB_OP_LE_GE     6'h16
`define CCB_OP_GT_LT     6'h17
`define CCB_OP_NE        6'h18
`define CCB_OP_BC        6'h32
`define CCB_OP_ZERO_LONG 6'h36
`define CCB_OP_BALC      6'h3A
`define CCB_OP_NZ_LONG   6'h3E
// sub-field codes
`define CCB_REG_ZERO     5'h00
`define CCB_RT_LIKELY_GE 5'h03
`define CCB_FN_JR        6'h08
`define CCB_FN_JALR      6'h09
`define CCB_FN_SLL       6'h00
`define CCB_FN_ERET      6'h18
`define CCB_FN_DERET     6'h1F
`define CCB_FN_WAIT      6'h20
`define CCB_SA_PAUSE     5'h05
`define CCB_CP_BC_EQZ    5'h09
`define CCB_CP_BC_NEZ    5'h0D
`define CCB_CP2_BC_EQZ   5'h09
// branch kinds
`define CCB_K_NONE       4'h0
`define CCB_K_REGS_EQ    4'h1
`define CCB_K_REGS_NE    4'h2
`define CCB_K_S_LT       4'h3
`define CCB_K_S_GE       4'h4
`define CCB_K_U_LT       4'h5
`define CCB_K_U_GE       4'h6
`define CCB_K_BELOW_Z    4'h7
`define CCB_K_AT_BELOW_Z 4'h8
`define CCB_K_AT_ABOVE_Z 4'h9
`define CCB_K_ABOVE_Z    4'hA
`define CCB_K_IS_Z_LONG  4'hB
`define CCB_K_NZ_LONG    4'hC
`define CCB_K_LIKELY_GE  4'hD
`define CCB_K_LAST       13
// address step of one instruction
`define CCB_INSN_BYTES   32'h0000_0004
`endif

// *** sim/ccb_regfile_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccb_regfile_model (
    input  wire logic        clk_sys,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [31:0] wr_val,
    input  wire logic [31:0] instr,
    output wire logic [31:0] rs_val,
    output wire logic [31:0] rt_val
);
    logic [31:0] regs [32];
    initial for (int i = 0; i < 32; i++) regs[i] = 32'h0000_0000;
    // register zero always reads zero
    always @(posedge clk_sys) begin
        if (wr_en && wr_idx != 5'h00) regs[wr_idx] <= wr_val;
    end
    assign rs_val = regs[instr[25:21]];
    assign rt_val = regs[instr[20:16]];
endmodule // ccb_regfile_model
`default_nettype wire

// *** sim/ccb_unit_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccb_unit_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_pc,
    input wire logic        resolve_q,
    input wire logic        is_compact_q,
    input wire logic        taken_q,
    input wire logic [3:0]  kind_q,
    input wire logic [31:0] target_q,
    input wire logic [31:0] fetch_pc_q,
    input wire logic        skip_next_q,
    input wire logic        nullify_slot_q,
    input wire logic        redirect_q,
    input wire logic [31:0] redirect_pc_q,
    input wire logic        reserved_instr_exc_q,
    input wire logic [31:0] exc_pc_q,
    input wire logic [13:1] kind_hit_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_taken_in_resolve: assert property (taken_q |-> resolve_q)
        else $error("taken flag without resolve");
    a_fetch_taken: assert property (resolve_q && taken_q |->
        fetch_pc_q == target_q) else $error("fetch address not target");
    a_fetch_seq: assert property ((clk_en && issue_valid) ##1
        (resolve_q && !taken_q) |-> fetch_pc_q == $past(issue_pc) + 32'h4)
        else $error("untaken fetch address not sequential");
    a_skip_on_taken: assert property (
        (resolve_q && is_compact_q && taken_q) == skip_next_q)
        else $error("skip flag mismatch");
    a_redirect_compact: assert property (skip_next_q |->
        redirect_q && redirect_pc_q == target_q)
        else $error("compact redirect wrong");
    a_nullify_likely: assert property (nullify_slot_q |->
        resolve_q && !taken_q && !is_compact_q && kind_q == 4'hD)
        else $error("nullify without untaken likely branch");
    a_exc_pc: assert property ($rose(reserved_instr_exc_q) |->
        exc_pc_q == $past(issue_pc)) else $error("exception address wrong");
    a_exc_no_eval: assert property (reserved_instr_exc_q |->
        !resolve_q && kind_q == 4'h0) else $error("excepted word evaluated");
    a_kind_onehot: assert property (kind_hit_q == (resolve_q ?
        13'h0001 << (kind_q - 4'h1) : 13'h0000))
        else $error("kind one-hot mismatch");
endmodule // ccb_unit_chk

bind ccb_unit ccb_unit_chk i_ccb_unit_chk (.*);
`default_nettype wire

// *** sim/ccb_unit_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccb_unit_test;
    localparam logic [31:0] PC = 32'h0000_1000;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0000_0000;
    logic [31:0] issue_pc = 32'h0000_0000;
    logic        wr_en = 1'b0;
    logic [4:0]  wr_idx = 5'h00;
    logic [31:0] wr_val = 32'h0000_0000;
    logic [31:0] regv [9] = '{32'h0, 32'h1234_5678, 32'h1234_5678,
        32'h9234_5678, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0,
        32'h8000_0000, 32'h7FFF_FFFF};
    wire [31:0]  first_source_val, second_source_val;
    wire         resolve_q, is_compact_q, taken_q, skip_next_q;
    wire         nullify_slot_q, redirect_q, reserved_instr_exc_q;
    wire [3:0]   kind_q;
    wire [31:0]  target_q, fetch_pc_q, redirect_pc_q, exc_pc_q;
    wire [13:1]  kind_hit_q;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;

    ccb_unit i_ccb_unit (.*);
    ccb_regfile_model i_ccb_regfile_model (.clk_sys(clk_sys),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_val(wr_val),
        .instr(issue_instr), .rs_val(first_source_val),
        .rt_val(second_source_val));

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done;
        end
    end

    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] enc(input logic [5:0] op,
        input logic [4:0] rs, input logic [4:0] rt, input logic [15:0] off);
        return {op, rs, rt, off};
    endfunction

    function automatic logic [31:0] t16(input logic [15:0] off);
        return PC + 32'h4 + {{14{off[15]}}, off, 2'b00};
    endfunction

    function automatic logic [31:0] t21(input logic [20:0] off);
        return PC + 32'h4 + {{9{off[20]}}, off, 2'b00};
    endfunction

    task automatic issue(input logic [31:0] ins, input logic [31:0] pc);
        issue_instr = ins;
        issue_pc = pc;
        issue_valid = 1'b1;
        @(negedge clk_sys);
    endtask

    task automatic idle;
        issue_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    // compact branch, then a plain word that must not trap
    task automatic br(input logic [31:0] ins, input logic [3:0] k,
        input logic tk, input logic [31:0] tgt);
        issue(ins, PC);
        chk_bit(resolve_q, 1'b1);
        chk_bit(taken_q, tk);
        chk_word({28'h0000000, kind_q}, {28'h0000000, k});
        chk_word(fetch_pc_q, tk ? tgt : PC + 32'h4);
        chk_bit(skip_next_q, tk);
        chk_bit(redirect_q, tk);
        issue(32'h0000_0000, PC + 32'h4);
        chk_bit(resolve_q, 1'b0);
        chk_bit(reserved_instr_exc_q, 1'b0);
        idle;
    endtask

    task automatic t_regs;
        br(enc(6'h08, 5'h01, 5'h02, 16'h8000), 4'h1, 1, t16(16'h8000));
        br(enc(6'h08, 5'h01, 5'h03, 16'h0010), 4'h1, 0, 0);
        br(enc(6'h18, 5'h01, 5'h03, 16'h7FFF), 4'h2, 1, t16(16'h7FFF));
        br(enc(6'h18, 5'h01, 5'h02, 16'h0010), 4'h2, 0, 0);
    endtask

    task automatic t_order;
        br(enc(6'h17, 5'h07, 5'h08, 16'h0020), 4'h3, 1, t16(16'h0020));
        br(enc(6'h16, 5'h07, 5'h08, 16'h0020), 4'h4, 0, 0);
        br(enc(6'h16, 5'h08, 5'h07, 16'hFFF0), 4'h4, 1, t16(16'hFFF0));
        br(enc(6'h07, 5'h07, 5'h08, 16'h0020), 4'h5, 0, 0);
        br(enc(6'h06, 5'h07, 5'h08, 16'h0020), 4'h6, 1, t16(16'h0020));
    endtask

    task automatic t_zero;
        br(enc(6'h16, 5'h00, 5'h04, 16'h0004), 4'h8, 1, t16(16'h0004));
        br(enc(6'h16, 5'h00, 5'h05, 16'h0004), 4'h8, 0, 0);
        br(enc(6'h16, 5'h06, 5'h06, 16'h0004), 4'h9, 1, t16(16'h0004));
        br(enc(6'h17, 5'h00, 5'h06, 16'h0004), 4'hA, 0, 0);
        br(enc(6'h17, 5'h04, 5'h04, 16'h0004), 4'h7, 1, t16(16'h0004));
        br(enc(6'h17, 5'h06, 5'h06, 16'h0004), 4'h7, 0, 0);
    endtask

    task automatic t_long;
        br({6'h36, 5'h06, 21'h100000}, 4'hB, 1, t21(21'h100000));
        br({6'h36, 5'h01, 21'h000010}, 4'hB, 0, 0);
        br({6'h3E, 5'h01, 21'h0FFFFF}, 4'hC, 1, t21(21'h0FFFFF));
        br({6'h3E, 5'h06, 21'h000010}, 4'hC, 0, 0);
    endtask

    task automatic t_forbid;
        logic [31:0] cti [8];
        cti = '{32'h0800_0000, 32'h03E0_0008, 32'h4200_0018, 32'h4200_001F,
                32'h4200_0020, 32'h0000_0140, 32'h0410_0000, 32'h1000_0000};
        for (int i = 0; i < 8; i++) begin
            issue(enc(6'h08, 5'h01, 5'h03, 16'h0010), PC);
            issue(cti[i], PC + 32'h4);
            chk_bit(reserved_instr_exc_q, 1'b1);
            chk_word(exc_pc_q, PC + 32'h4);
            issue(32'h0000_0000, PC + 32'h8);
            chk_bit(reserved_instr_exc_q, 1'b0);
        end
        issue(enc(6'h08, 5'h01, 5'h02, 16'h0010), PC);
        issue(32'h0800_0000, PC + 32'h4);
        chk_bit(reserved_instr_exc_q, 1'b0);
        issue(32'h0000_0000, PC + 32'h8);
        idle;
    endtask

    task automatic t_likely;
        issue(enc(6'h01, 5'h05, 5'h03, 16'hFFFE), PC);
        chk_bit(taken_q, 1'b1);
        chk_bit(nullify_slot_q, 1'b0);
        chk_word({28'h0000000, kind_q}, 32'h0000_000D);
        issue(32'h0000_0000, PC + 32'h4);
        chk_bit(redirect_q, 1'b1);
        chk_word(redirect_pc_q, t16(16'hFFFE));
        issue(enc(6'h01, 5'h04, 5'h03, 16'h0040), PC);
        chk_bit(taken_q, 1'b0);
        chk_bit(nullify_slot_q, 1'b1);
        issue(32'h0000_0000, PC + 32'h4);
        chk_bit(redirect_q, 1'b0);
        idle;
    endtask

    task automatic t_hold;
        issue(enc(6'h08, 5'h01, 5'h02, 16'h0010), PC);
        clk_en = 1'b0;
        issue(32'h0000_0000, PC + 32'h4);
        chk_bit(resolve_q, 1'b1);
        clk_en = 1'b1;
        issue(32'h0000_0000, PC + 32'h4);
        chk_bit(resolve_q, 1'b0);
        idle;
    endtask

    initial begin
        for (int i = 1; i < 9; i++) begin
            @(negedge clk_sys);
            wr_en = 1'b1;
            wr_idx = i[4:0];
            wr_val = regv[i];
        end
        @(negedge clk_sys);
        wr_en = 1'b0;
        repeat (11) @(negedge clk_sys);
        rst = 1'b0;
        chk_bit(resolve_q, 1'b0);
        t_regs;
        t_order;
        t_zero;
        t_long;
        t_forbid;
        t_likely;
        t_hold;
        test_done;
    end
endmodule // ccb_unit_test
`default_nettype wire
